// file: glfa_top.sv
// Genlock frame alignment and reference and lock status with AHB-Lite registers
`timescale 1ns/1ns
`include "glfa_defs.svh"
module glfa_top
    import glfa_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic hsync_in,
    input wire logic vsync_in,
    input wire logic phase_cmp_strobe,
    input wire logic phase_err_over,
    input wire logic hd_pll_lock_in,
    input wire logic divider_match_in,
    input wire logic vcxo_near_rail_in,
    output logic frame_start_pulse_o,
    output logic frame_start_pulse_oe,
    output logic reference_loss,
    output logic lock_fail,
    output logic freerun_active,
    output logic holdover_active
);

    glfa_state_s s_r;
    glfa_state_s s_nxt;

    function automatic logic [3:0] ref_div_value(input logic [1:0] code);
        case (code)
            2'b00: ref_div_value = 4'h2;
            2'b01: ref_div_value = 4'h1;
            2'b10: ref_div_value = 4'h5;
            default: ref_div_value = 4'h1;
        endcase
    endfunction : ref_div_value

    function automatic logic [31:0] read_reg(input glfa_state_s st, input logic [7:0] idx);
        read_reg = 32'h0000_0000;
        case (idx)
            `GLFA_IDX_MODE: read_reg = {24'h00_0000, st.mode};
            `GLFA_IDX_STATUS: begin
                read_reg[`GLFA_ST_HD] = st.sync.hd_sync2;
                read_reg[`GLFA_ST_SD] = st.vcxo_pll_locked;
                read_reg[`GLFA_ST_VALID] = st.ref_valid;
            end
            `GLFA_IDX_REFDIV: read_reg = {30'h0000_0000, st.ref_div};
            `GLFA_IDX_HIZ: read_reg = {24'h00_0000, st.hiz};
            `GLFA_IDX_RATIO: read_reg = {16'h0000, st.ratio};
            `GLFA_IDX_OPPL: read_reg = {19'h0_0000, st.out_ppl};
            `GLFA_IDX_OLPFM: read_reg = {20'h0_0000, st.out_lpfm};
            `GLFA_IDX_RLPFM: read_reg = {20'h0_0000, st.ref_lines_per_frame};
            `GLFA_IDX_OFFSET: read_reg = {20'h0_0000, st.line_offset};
            `GLFA_IDX_HPERIOD: read_reg = {16'h0000, st.h_period};
            default: read_reg = 32'h0000_0000;
        endcase
    endfunction : read_reg

    logic addr_ok;
    logic hsync_rise;
    logic coincide;
    logic line_match;
    logic h_good;
    logic h_miss;
    logic [11:0] thr;
    logic ref_ok;
    logic align_now;
    logic gl_en;

    always_comb begin
        s_nxt = s_r;
        addr_ok = hsel && hready && htrans == `GLFA_HTRANS_NONSEQ;
        gl_en = s_r.mode[`GLFA_MODE_GENLOCK];
        // Register write, data phase
        if (s_r.wr_pend) begin
            case (s_r.wr_idx)
                `GLFA_IDX_MODE: s_nxt.mode = hwdata[7:0];
                `GLFA_IDX_REFDIV: s_nxt.ref_div = hwdata[1:0];
                `GLFA_IDX_HIZ: s_nxt.hiz = hwdata[7:0];
                `GLFA_IDX_RATIO: s_nxt.ratio = hwdata[15:0];
                `GLFA_IDX_OPPL: s_nxt.out_ppl = hwdata[12:0];
                `GLFA_IDX_OLPFM: s_nxt.out_lpfm = hwdata[11:0];
                `GLFA_IDX_RLPFM: s_nxt.ref_lines_per_frame = hwdata[11:0];
                `GLFA_IDX_OFFSET: s_nxt.line_offset = hwdata[11:0];
                `GLFA_IDX_HPERIOD: s_nxt.h_period = hwdata[15:0];
                default: s_nxt.wr_pend = 1'b0;
            endcase
        end
        s_nxt.wr_pend = addr_ok && hwrite;
        s_nxt.wr_idx = haddr[9:2];
        // Status inputs synchronised
        s_nxt.sync.hd_sync1 = hd_pll_lock_in;
        s_nxt.sync.hd_sync2 = s_r.sync.hd_sync1;
        s_nxt.sync.div_sync1 = divider_match_in;
        s_nxt.sync.div_sync2 = s_r.sync.div_sync1;
        s_nxt.sync.rail_sync1 = vcxo_near_rail_in;
        s_nxt.sync.rail_sync2 = s_r.sync.rail_sync1;
        // H sync period check, V sync ignored
        s_nxt.hsync_prev = hsync_in;
        hsync_rise = hsync_in && !s_r.hsync_prev;
        h_good = hsync_rise && s_r.h_timer >= s_r.h_period - `GLFA_HTOL
            && s_r.h_timer <= s_r.h_period + `GLFA_HTOL;
        h_miss = !hsync_rise && s_r.h_timer >= s_r.h_period + `GLFA_HTOL;
        if (hsync_rise || h_miss) begin
            s_nxt.h_timer = 16'h0000;
        end else begin
            s_nxt.h_timer = s_r.h_timer + 16'h0001;
        end
        if (h_good) begin
            s_nxt.missing = 8'h00;
        end else if (h_miss && s_r.missing != 8'hFF) begin
            s_nxt.missing = s_r.missing + 8'h01;
        end
        thr = 12'(s_r.mode[3:0]) * 12'(ref_div_value(s_r.ref_div));
        ref_ok = gl_en && s_r.sync.div_sync2 && !s_r.sync.rail_sync2;
        if (!ref_ok || 12'(s_r.missing) > thr) begin
            s_nxt.ref_valid = 1'b0;
        end else if (h_good) begin
            s_nxt.ref_valid = 1'b1;
        end
        // Lock detector
        if (!s_r.ref_valid) begin
            s_nxt.vcxo_pll_locked = 1'b0;
            s_nxt.lock_run = 2'h0;
        end else if (phase_cmp_strobe) begin
            if (phase_err_over == s_r.vcxo_pll_locked) begin
                if (s_r.lock_run == `GLFA_LOCK_RUN - 2'h1) begin
                    s_nxt.vcxo_pll_locked = !s_r.vcxo_pll_locked;
                    s_nxt.lock_run = 2'h0;
                end else begin
                    s_nxt.lock_run = s_r.lock_run + 2'h1;
                end
            end else begin
                s_nxt.lock_run = 2'h0;
            end
        end
        // Reference frame decoder
        coincide = hsync_rise && vsync_in;
        line_match = 1'b0;
        if (coincide) begin
            s_nxt.ref_line = 12'h000;
            line_match = s_r.line_offset == s_r.ref_lines_per_frame;
            if (s_r.ratio_cnt + 13'h0001 >= s_r.ratio[12:0]) begin
                s_nxt.ratio_cnt = 13'h0000;
            end else begin
                s_nxt.ratio_cnt = s_r.ratio_cnt + 13'h0001;
            end
        end else if (hsync_rise) begin
            s_nxt.ref_line = s_r.ref_line + 12'h001;
            line_match = s_r.ref_line + 12'h001 == s_r.line_offset;
        end
        // Alignment arming
        s_nxt.init_prev = s_r.ratio[`GLFA_RATIO_INIT];
        if (!s_r.ratio[`GLFA_RATIO_ENABLE]) begin
            s_nxt.armed = 1'b0;
        end else if (s_r.ratio[`GLFA_RATIO_INIT] && !s_r.init_prev) begin
            s_nxt.armed = 1'b1;
        end
        align_now = s_r.armed && s_r.ratio[`GLFA_RATIO_ENABLE] && s_r.ref_valid
            && line_match && s_r.ratio_cnt == 13'h0000;
        // Output counters, free running between alignments
        if (align_now) begin
            s_nxt.pix = 13'h0000;
            s_nxt.line = 12'h000;
        end else if (s_r.pix + 13'h0001 >= s_r.out_ppl) begin
            s_nxt.pix = 13'h0000;
            if (s_r.line + 12'h001 >= s_r.out_lpfm) begin
                s_nxt.line = 12'h000;
            end else begin
                s_nxt.line = s_r.line + 12'h001;
            end
        end else begin
            s_nxt.pix = s_r.pix + 13'h0001;
        end
        s_nxt.frame_pulse = s_nxt.line == 12'h000;
        // Read data for the coming data phase
        s_nxt.rdata = s_r.rdata;
        if (addr_ok && !hwrite) begin
            s_nxt.rdata = read_reg(s_nxt, haddr[9:2]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.mode <= `GLFA_RST_MODE;
            s_r.h_period <= `GLFA_RST_HPERIOD;
            s_r.out_ppl <= `GLFA_RST_OPPL;
            s_r.out_lpfm <= `GLFA_RST_LPFM;
            s_r.ref_lines_per_frame <= `GLFA_RST_LPFM;
            s_r.line_offset <= `GLFA_RST_LPFM;
            s_r.ratio <= 16'h0001;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign frame_start_pulse_o = s_r.frame_pulse;
    assign frame_start_pulse_oe = !s_r.hiz[`GLFA_HIZ_FRAME];
    assign reference_loss = !s_r.ref_valid;
    assign lock_fail = !(s_r.ref_valid && s_r.vcxo_pll_locked && s_r.sync.hd_sync2);
    assign freerun_active = gl_en && !s_r.ref_valid
        && !s_r.mode[`GLFA_MODE_HOLDOVER];
    assign holdover_active = gl_en && !s_r.ref_valid && s_r.mode[`GLFA_MODE_HOLDOVER];

endmodule : glfa_top

// file: glfa_defs.svh
// Register offsets, field positions and timing constants of the genlock frame aligner
`ifndef GLFA_DEFS_SVH
`define GLFA_DEFS_SVH
`define GLFA_IDX_MODE 8'h00
`define GLFA_IDX_STATUS 8'h01
`define GLFA_IDX_REFDIV 8'h03
`define GLFA_IDX_HIZ 8'h08
`define GLFA_IDX_RATIO 8'h09
`define GLFA_IDX_OPPL 8'h0B
`define GLFA_IDX_OLPFM 8'h0D
`define GLFA_IDX_RLPFM 8'h0F
`define GLFA_IDX_OFFSET 8'h11
`define GLFA_IDX_HPERIOD 8'h14
`define GLFA_MODE_GENLOCK 7
`define GLFA_MODE_HOLDOVER 6
`define GLFA_RATIO_INIT 14
`define GLFA_RATIO_ENABLE 15
`define GLFA_HIZ_FRAME 2
`define GLFA_ST_HD 2
`define GLFA_ST_SD 1
`define GLFA_ST_VALID 0
`define GLFA_HTOL 16'h0010
`define GLFA_LOCK_RUN 2'h3
`define GLFA_RST_MODE 8'h00
`define GLFA_RST_HPERIOD 16'h035A
`define GLFA_RST_OPPL 13'h06B4
`define GLFA_RST_LPFM 12'h020D
`define GLFA_HTRANS_NONSEQ 2'h2
`endif

// file: glfa_pkg.sv
// Types of the genlock frame aligner
package glfa_pkg;
    typedef struct packed {
        logic hd_sync1;
        logic hd_sync2;
        logic div_sync1;
        logic div_sync2;
        logic rail_sync1;
        logic rail_sync2;
    } glfa_sync_s;
    typedef struct packed {
        logic [7:0] mode;
        logic [1:0] ref_div;
        logic [7:0] hiz;
        logic [15:0] ratio;
        logic [12:0] out_ppl;
        logic [11:0] out_lpfm;
        logic [11:0] ref_lines_per_frame;
        logic [11:0] line_offset;
        logic [15:0] h_period;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        glfa_sync_s sync;
        logic hsync_prev;
        logic [15:0] h_timer;
        logic [7:0] missing;
        logic ref_valid;
        logic vcxo_pll_locked;
        logic [1:0] lock_run;
        logic init_prev;
        logic armed;
        logic [11:0] ref_line;
        logic [12:0] ratio_cnt;
        logic [12:0] pix;
        logic [11:0] line;
        logic frame_pulse;
    } glfa_state_s;
endpackage : glfa_pkg

// file: glfa_ref_src.sv
// Reference H and V sync source model
`timescale 1ns/1ns
module glfa_ref_src (
    input wire logic clk,
    input wire logic run,
    output logic hsync = 1'b0,
    output logic vsync = 1'b0
);
    logic [5:0] pix = '0;
    logic [1:0] line = '0;
    always @(posedge clk) begin
        pix <= (pix == 6'd39) ? 6'd0 : pix + 6'd1;
        if (pix == 6'd39) begin
            line <= line + 2'd1;
        end
        hsync <= run && pix < 6'd4;
        vsync <= run && line == 2'd0;
    end
endmodule : glfa_ref_src

// file: glfa_monitor.sv
// Port assertions for the genlock frame aligner
`timescale 1ns/1ns
module glfa_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hsync_in,
    input wire logic divider_match_in,
    input wire logic vcxo_near_rail_in,
    input wire logic frame_start_pulse_oe,
    input wire logic reference_loss,
    input wire logic lock_fail,
    input wire logic freerun_active,
    input wire logic holdover_active
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic hiz_wr_r;
    logic [6:0] quiet_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hiz_wr_r <= 1'b0;
            quiet_r <= '0;
        end else begin
            hiz_wr_r <= hsel && htrans == 2'h2 && hwrite && haddr[9:2] == 8'h08;
            quiet_r <= hsync_in ? 7'h00 : quiet_r + {6'h00, quiet_r != 7'h7F};
        end
    end
    hiz_float_a: assert property (hiz_wr_r && hwdata[2] |=> !frame_start_pulse_oe)
        else $error("frame pulse still driven");
    hiz_drive_a: assert property (hiz_wr_r && !hwdata[2] |=> frame_start_pulse_oe)
        else $error("frame pulse not driven");
    freerun_excl_a: assert property (freerun_active |-> reference_loss && !holdover_active)
        else $error("free run without loss");
    holdover_loss_a: assert property (holdover_active |-> reference_loss)
        else $error("holdover without loss");
    rail_invalid_a: assert property (vcxo_near_rail_in [*3] |-> ##[0:2] reference_loss)
        else $error("valid near rail");
    divider_bad_a: assert property (!divider_match_in [*3] |-> ##[0:2] reference_loss)
        else $error("valid with bad dividers");
    valid_edge_a: assert property ($fell(reference_loss) |->
        $past(hsync_in, 1) || $past(hsync_in, 2) || $past(hsync_in, 3))
        else $error("valid without H edge");
    hsync_gone_a: assert property (quiet_r >= 7'd100 |-> reference_loss)
        else $error("no loss after missing H");
    lockfail_nand_a: assert property (!lock_fail |-> !reference_loss)
        else $error("lock reported without reference");
endmodule : glfa_monitor

// file: test_genlock_frame_align_status.sv
// Self-checking bench for the genlock frame aligner
`timescale 1ns/1ns
`include "glfa_defs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_genlock_frame_align_status;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0, hreadyout, hresp;
    logic run = 1'b0, strobe = 1'b0, over = 1'b0, hd_pll_locked = 1'b0, div_ok = 1'b1, rail = 1'b0;
    logic hsync, vsync, fsp, fsp_oe, ref_loss, lock_fail, freerun, holdover;
    int mismatches = 0, checks_done = 0;
    always #4 hclk = ~hclk;
    glfa_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hsync_in(hsync),
        .vsync_in(vsync), .phase_cmp_strobe(strobe), .phase_err_over(over),
        .hd_pll_lock_in(hd_pll_locked), .divider_match_in(div_ok), .vcxo_near_rail_in(rail),
        .frame_start_pulse_o(fsp), .frame_start_pulse_oe(fsp_oe), .reference_loss(ref_loss),
        .lock_fail(lock_fail), .freerun_active(freerun), .holdover_active(holdover));
    glfa_ref_src i_src (.clk(hclk), .run(run), .hsync(hsync), .vsync(vsync));
    task tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    task wr(input logic [7:0] i, input logic [31:0] d);
        haddr <= {22'h0, i, 2'b00};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : wr
    task rd(input logic [7:0] i, input logic [31:0] e);
        haddr <= {22'h0, i, 2'b00};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        `CHK(hrdata, e)
    endtask : rd
    task pulse(input logic o);
        strobe <= 1'b1;
        over <= o;
        tick(1);
        strobe <= 1'b0;
        tick(3);
    endtask : pulse
    task conclude;
        $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task t_reset;
        rd(`GLFA_IDX_MODE, 32'h0000_0000);
        rd(`GLFA_IDX_RATIO, 32'h0000_0001);
        rd(`GLFA_IDX_OFFSET, 32'h0000_020D);
        wr(8'h3F, 32'hFFFF_FFFF);
        rd(8'h3F, 32'h0000_0000);
        `CHK(ref_loss, 1'b1)
        `CHK(lock_fail, 1'b1)
    endtask : t_reset
    task t_valid;
        wr(`GLFA_IDX_HPERIOD, 32'h0000_0028);
        wr(`GLFA_IDX_REFDIV, 32'h0000_0001);
        wr(`GLFA_IDX_MODE, 32'h0000_0080);
        run <= 1'b1;
        tick(200);
        rd(`GLFA_IDX_STATUS, 32'h0000_0001);
        `CHK(ref_loss, 1'b0)
        `CHK(lock_fail, 1'b1)
        rail <= 1'b1;
        tick(8);
        `CHK(ref_loss, 1'b1)
        rail <= 1'b0;
        tick(100);
        `CHK(ref_loss, 1'b0)
        div_ok <= 1'b0;
        tick(8);
        `CHK(ref_loss, 1'b1)
        div_ok <= 1'b1;
        tick(100);
    endtask : t_valid
    task t_lock;
        hd_pll_locked <= 1'b1;
        pulse(1'b0);
        pulse(1'b0);
        rd(`GLFA_IDX_STATUS, 32'h0000_0005);
        pulse(1'b0);
        rd(`GLFA_IDX_STATUS, 32'h0000_0007);
        `CHK(lock_fail, 1'b0)
        pulse(1'b1);
        pulse(1'b1);
        pulse(1'b0);
        rd(`GLFA_IDX_STATUS, 32'h0000_0007);
    endtask : t_lock
    task t_align;
        `CHK(lock_fail, 1'b0)
        wr(`GLFA_IDX_OPPL, 32'h0000_000A);
        wr(`GLFA_IDX_OLPFM, 32'h0000_0004);
        wr(`GLFA_IDX_RLPFM, 32'h0000_0004);
        wr(`GLFA_IDX_OFFSET, 32'h0000_0004);
        wr(`GLFA_IDX_RATIO, 32'h0000_8001);
        wr(`GLFA_IDX_RATIO, 32'h0000_C001);
        while (hsync) tick(1);
        while (!(hsync && vsync)) tick(1);
        tick(4);
        `CHK(fsp, 1'b1)
        tick(12);
        `CHK(fsp, 1'b0)
        wr(`GLFA_IDX_RATIO, 32'h0000_0001);
    endtask : t_align
    task t_loss;
        int n;
        logic p;
        wr(`GLFA_IDX_HIZ, 32'h0000_0004);
        tick(2);
        `CHK(fsp_oe, 1'b0)
        wr(`GLFA_IDX_HIZ, 32'h0000_0000);
        tick(2);
        `CHK(fsp_oe, 1'b1)
        wr(`GLFA_IDX_MODE, 32'h0000_00C0);
        run <= 1'b0;
        tick(100);
        `CHK(ref_loss, 1'b1)
        `CHK(holdover, 1'b1)
        rd(`GLFA_IDX_STATUS, 32'h0000_0004);
        n = 0;
        p = fsp;
        repeat (120) begin
            tick(1);
            n += (fsp === 1'b1 && p === 1'b0);
            p = fsp;
        end
        `CHK(n, 3)
        wr(`GLFA_IDX_MODE, 32'h0000_0080);
        tick(2);
        `CHK(freerun, 1'b1)
        `CHK(holdover, 1'b0)
    endtask : t_loss
    initial begin
        tick(10);
        hresetn <= 1'b1;
        tick(1);
        t_reset;
        t_valid;
        t_lock;
        t_align;
        t_loss;
        conclude;
    end
    initial begin
        tick(20000);
        mismatches++;
        conclude;
    end
endmodule : test_genlock_frame_align_status
bind glfa_top glfa_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hsync_in(hsync_in),
    .divider_match_in(divider_match_in), .vcxo_near_rail_in(vcxo_near_rail_in),
    .frame_start_pulse_oe(frame_start_pulse_oe), .reference_loss(reference_loss),
    .lock_fail(lock_fail), .freerun_active(freerun_active), .holdover_active(holdover_active));
